// ==== dpw_master_model.sv ====
// dpw_master_model: behavioural two-wire bus master for the wiper command unit
// assumes a pull-up on sda; the bench resolves the wire from both pull-down enables
`timescale 1ns/1ps
`default_nettype none
module dpw_master_model (
  output var  logic o_scl,
  output var  logic o_sda_low,
  input  wire logic i_sda
);
  // bus clock stands high between frames, 6 ns period inside them
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic bit_cycle(input logic b, output logic seen);
    #1 o_sda_low = ~b;
    #2 o_scl = 1'b1;
    #1.5 seen = i_sda;
    #1.5 o_scl = 1'b0;
  endtask

  // start, n bytes msb first each with a released ack slot, stop
  task automatic send(input logic [7:0] bytes [4], input int n, output logic [3:0] acks);
    logic s;
    acks = 4'h0;
    o_sda_low = 1'b1;
    #3 o_scl = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int k = 7; k >= 0; k--) begin
        bit_cycle(bytes[i][k], s);
      end
      bit_cycle(1'b1, s);
      acks[i] = ~s;
    end
    #1 o_sda_low = 1'b1;
    #2 o_scl = 1'b1;
    #3 o_sda_low = 1'b0;
    #3;
  endtask
endmodule // dpw_master_model
`default_nettype wire

// ==== dpw_pkg.sv ====
// dpw_pkg: constants, command codes and states of the wiper command unit
// assumes a 100 MHz system clock; shared by the top and the testbench
package dpw_pkg;
  localparam int          CLK_HZ        = 100_000_000;
  localparam int          INIT_TIME_NS  = 20_000;
  localparam int          INIT_CYC      = (INIT_TIME_NS / 1000) * (CLK_HZ / 1_000_000);
  localparam int          NV_PROG_MS    = 12;
  localparam int          NV_PROG_CYC   = NV_PROG_MS * (CLK_HZ / 1000);
  localparam int          INIT_W        = 12;
  localparam int          PROG_W        = 21;
  localparam int          BYTE_W        = 8;
  localparam int          WIPER_W       = 5;
  localparam int          WIPER_LSB     = 3;
  localparam logic [3:0]  ADDR_HIGH     = 4'h5;
  localparam logic [3:0]  ACK_BIT       = 4'h8;
  localparam logic [3:0]  LAST_BIT      = 4'h7;
  localparam logic [3:0]  FIRST_BIT     = 4'h1;
  localparam logic [1:0]  IDX_ADDR      = 2'h0;
  localparam logic [1:0]  IDX_CMD       = 2'h1;
  localparam logic [1:0]  IDX_DATA      = 2'h2;
  localparam logic [1:0]  IDX_REST      = 2'h3;
  localparam logic [7:0]  CMD_VOL_WR    = 8'h11;
  localparam logic [7:0]  CMD_NV_WR     = 8'h21;
  localparam logic [7:0]  CMD_RECALL    = 8'h61;
  localparam logic [7:0]  CMD_STORE     = 8'h51;
  localparam logic [4:0]  NV_FACTORY    = 5'h00;
  localparam logic [4:0]  WIPER_RESET   = 5'h00;

  typedef enum logic [1:0] {
    DPW_INIT = 2'b00,
    DPW_IDLE = 2'b01,
    DPW_PROG = 2'b11
  } dpw_state_t;
endpackage

// ==== dpw_sync.sv ====
// dpw_sync: two-flop synchroniser for single-bit levels and toggles
// assumes the input is a level that stays put for at least two clock edges
`timescale 1ns/1ps
`default_nettype none
module dpw_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_async,
  output var  logic o_sync
);
  logic meta;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta   <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // dpw_sync
`default_nettype wire

// ==== dpw_tb.sv ====
// testbench: self-checking bench of the wiper command unit
// assumes dpw_master_model as bus master and a shortened programming time
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dpw_pkg::*;
  localparam int PROG = 50;
  logic               i_clk;
  logic               i_rst;
  logic               i_nv_clear;
  logic               strap;
  wire                scl;
  wire                sda_low;
  wire                sda_wire;
  logic               sda_out;
  logic               sda_oe;
  logic               busy;
  logic               standby;
  logic [WIPER_W-1:0] wiper;
  logic [WIPER_W-1:0] nv;
  logic [3:0]         acks;
  int                 n_fail;
  int                 n_tests;

  assign sda_wire = ~(sda_low | sda_oe);

  dpw_master_model m (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda_wire));

  dpw_wiper_cmd #(.ADDR_BIT_TWO(1'b0), .ADDR_BIT_ONE(1'b0), .PROG_CYC(PROG)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_nv_clear(i_nv_clear), .i_scl(scl), .i_sda(sda_wire),
    .i_address_select_input(strap), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_wiper(wiper),
    .o_nv_value(nv), .o_nv_busy(busy), .o_standby(standby));

  always #5 i_clk = ~i_clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // frame then the required idle gap on the system clock
  task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input int n);
    logic [7:0] b [4];
    b = '{a, c, d, 8'ha5};
    m.send(b, n, acks);
    cycles(25);
  endtask

  // bounded wait for the programming timer
  task automatic wait_idle;
    int k;
    for (k = 0; k < PROG + 20 && busy !== 1'b0; k++) cycles(1);
    if (busy !== 1'b0) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic t_power_up;
    cycles(2010);
    check(8'(wiper), 8'h00, "wiper after init");
    check(8'(nv), 8'h00, "factory value");
    check(8'(standby), 8'h01, "standby idle");
    check(8'(sda_out), 8'h00, "sda drive level");
  endtask

  task automatic t_vol_write;
    frame(8'h50, CMD_VOL_WR, 8'haf, 3);
    check(8'(acks), 8'h07, "acks");
    check(8'(wiper), 8'h15, "wiper bits");
    check(8'(nv), 8'h00, "nv kept");
  endtask

  task automatic t_nv_write;
    frame(8'h50, CMD_NV_WR, 8'h3f, 3);
    check(8'(busy), 8'h01, "busy");
    check(8'(standby), 8'h00, "no standby");
    check(8'(nv), 8'h00, "nv before timer");
    wait_idle();
    check(8'(nv), 8'h07, "nv written");
    check(8'(wiper), 8'h15, "wiper kept");
    check(8'(standby), 8'h01, "standby after programming");
  endtask

  task automatic t_recall_store;
    frame(8'h50, CMD_RECALL, 8'h00, 3);
    check(8'(wiper), 8'h07, "recall");
    frame(8'h50, CMD_VOL_WR, 8'hf8, 3);
    frame(8'h50, CMD_STORE, 8'h00, 3);
    wait_idle();
    check(8'(nv), 8'h1f, "store");
  endtask

  task automatic t_refused;
    frame(8'h70, CMD_VOL_WR, 8'h00, 3);
    check(8'(acks), 8'h00, "bad address acks");
    frame(8'h51, CMD_VOL_WR, 8'h00, 3);
    check(8'(acks), 8'h01, "nop acks");
    frame(8'h50, 8'h12, 8'h00, 3);
    check(8'(acks), 8'h07, "unknown cmd acks");
    check({3'h0, wiper}, 8'h1f, "wiper untouched");
    check(8'(nv), 8'h1f, "nv untouched");
    frame(8'h50, CMD_VOL_WR, 8'h08, 4);
    check(8'(acks), 8'h0f, "extra byte acked");
    check(8'(wiper), 8'h01, "first data byte only");
    strap = 1'b1;
    frame(8'h50, CMD_VOL_WR, 8'h00, 3);
    check(8'(acks), 8'h00, "strap moves address");
    check(8'(wiper), 8'h01, "strap miss ignored");
    frame(8'h52, CMD_VOL_WR, 8'h10, 3);
    check(8'(acks), 8'h07, "strap address acks");
    check(8'(wiper), 8'h02, "strap address write");
    strap = 1'b0;
  endtask

  task automatic t_power_cycle;
    i_rst = 1'b1;
    cycles(3);
    check(8'(wiper), 8'h00, "wiper lost");
    i_rst = 1'b0;
    cycles(1990);
    check(8'(wiper), 8'h00, "still loading");
    cycles(20);
    check(8'(wiper), 8'h1f, "reloaded");
    check(8'(nv), 8'h1f, "memory kept");
  endtask

  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    i_nv_clear = 1'b1;
    strap = 1'b0;
    n_fail = 0;
    n_tests = 0;
    cycles(6);
    i_rst = 1'b0;
    i_nv_clear = 1'b0;
    t_power_up();
    t_vol_write();
    t_nv_write();
    t_recall_store();
    t_refused();
    t_power_cycle();
    stop_test();
  end
endmodule // testbench
`default_nettype wire

// ==== dpw_wiper_cmd.sv ====
// dpw_wiper_cmd: two-wire command decoder of a 32-tap stored-wiper potentiometer
// assumes scl/sda come from the bus master; sda drive is open drain via o_sda_oe
`timescale 1ns/1ps
`default_nettype none
module dpw_wiper_cmd
  import dpw_pkg::*;
#(
  parameter logic     ADDR_BIT_TWO = 1'b0,
  parameter logic     ADDR_BIT_ONE = 1'b0,
  parameter int       PROG_CYC     = dpw_pkg::NV_PROG_CYC
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_nv_clear,
  input  wire logic                      i_scl,
  input  wire logic                      i_sda,
  input  wire logic                      i_address_select_input,
  output var  logic                      o_sda_out,
  output var  logic                      o_sda_oe,
  output var  logic [dpw_pkg::WIPER_W-1:0] o_wiper,
  output var  logic [dpw_pkg::WIPER_W-1:0] o_nv_value,
  output var  logic                      o_nv_busy,
  output logic                           o_standby
);
  import dpw_pkg::*;

  // link side: start/stop on sda edges
  logic start_tgl;
  logic stop_tgl;

  always_ff @(negedge i_sda or posedge i_rst) begin
    if (i_rst) start_tgl <= 1'b0;
    else if (i_scl) start_tgl <= ~start_tgl;
  end

  always_ff @(posedge i_sda or posedge i_rst) begin
    if (i_rst) stop_tgl <= 1'b0;
    else if (i_scl) stop_tgl <= ~stop_tgl;
  end

  // link side: byte receiver on scl
  logic                start_seen;
  logic [3:0]          bit_cnt;
  logic [1:0]          byte_idx;
  logic [BYTE_W-2:0]   shreg;
  logic                addressed;
  logic                ack_pend;
  logic [BYTE_W-1:0]   cmd_q;
  logic [BYTE_W-1:0]   data_q;
  logic                evt_tgl;
  logic                sel_s;

  dpw_sync u_sel_sync (
    .i_clk   (i_scl),
    .i_rst   (i_rst),
    .i_async (i_address_select_input),
    .o_sync  (sel_s)
  );

  wire                new_start  = start_tgl != start_seen;
  wire                byte_end   = bit_cnt == LAST_BIT;
  wire [BYTE_W-1:0]   rx_byte    = {shreg, i_sda};
  wire [6:0]          own_addr   = {ADDR_HIGH, ADDR_BIT_TWO, ADDR_BIT_ONE, sel_s};
  wire                addr_hit   = rx_byte[BYTE_W-1:1] == own_addr;
  wire                rw_write   = ~rx_byte[0];
  wire                at_addr    = byte_idx == IDX_ADDR;
  wire                take_ack   = at_addr ? addr_hit : addressed;
  wire [1:0]          next_idx   = (byte_idx == IDX_REST) ? IDX_REST : byte_idx + 2'h1;

  always_ff @(posedge i_scl or posedge i_rst) begin
    if (i_rst) begin
      start_seen <= 1'b0;
      bit_cnt    <= 4'h0;
      byte_idx   <= IDX_ADDR;
      shreg      <= '0;
      addressed  <= 1'b0;
      ack_pend   <= 1'b0;
      cmd_q      <= 8'h00;
      data_q     <= 8'h00;
      evt_tgl    <= 1'b0;
    end else if (new_start) begin
      start_seen <= start_tgl;
      bit_cnt    <= FIRST_BIT;
      byte_idx   <= IDX_ADDR;
      shreg      <= {{(BYTE_W-2){1'b0}}, i_sda};
      addressed  <= 1'b0;
      ack_pend   <= 1'b0;
    end else if (bit_cnt == ACK_BIT) begin
      bit_cnt  <= 4'h0;
      byte_idx <= next_idx;
    end else begin
      shreg   <= rx_byte[BYTE_W-2:0];
      bit_cnt <= bit_cnt + 4'h1;
      if (byte_end) begin
        ack_pend <= take_ack;
        if (at_addr) addressed <= addr_hit;
        if (byte_idx == IDX_ADDR && addr_hit && !rw_write) addressed <= 1'b0;
        if (byte_idx == IDX_CMD && addressed) cmd_q <= rx_byte;
        if (byte_idx == IDX_DATA && addressed) begin
          data_q  <= rx_byte;
          evt_tgl <= ~evt_tgl;
        end
      end
    end
  end

  // ack drive changes on falling scl, held through the ninth high phase
  wire next_oe = (bit_cnt == ACK_BIT) && ack_pend;

  always_ff @(negedge i_scl or posedge i_rst) begin
    if (i_rst) o_sda_oe <= 1'b0;
    else o_sda_oe <= next_oe;
  end

  assign o_sda_out = 1'b0;

  // crossings into the system clock
  // cmd_q stays still after the toggle moves until the command byte of the next frame, data_q until its data byte
  logic evt_s;
  logic evt_d;
  logic bus_active_s;

  dpw_sync u_evt_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (evt_tgl),
    .o_sync  (evt_s)
  );

  dpw_sync u_bus_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (start_tgl ^ stop_tgl),
    .o_sync  (bus_active_s)
  );

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) evt_d <= 1'b0;
    else evt_d <= evt_s;
  end

  // system side: registers and timers
  dpw_state_t          state;
  dpw_state_t          next_state;
  logic [INIT_W-1:0]   init_cnt;
  logic [PROG_W-1:0]   prog_cnt;
  logic [WIPER_W-1:0]  nv_pend;

  wire                 cmd_evt    = (evt_s ^ evt_d) && state == DPW_IDLE;
  wire [WIPER_W-1:0]   data_pos   = data_q[WIPER_LSB +: WIPER_W];
  wire                 do_vol_wr  = cmd_evt && cmd_q == CMD_VOL_WR;
  wire                 do_nv_wr   = cmd_evt && cmd_q == CMD_NV_WR;
  wire                 do_recall  = cmd_evt && cmd_q == CMD_RECALL;
  wire                 do_store   = cmd_evt && cmd_q == CMD_STORE;
  wire                 init_done  = state == DPW_INIT && init_cnt == '0;
  wire                 prog_done  = state == DPW_PROG && prog_cnt == '0;
  wire [PROG_W-1:0]    prog_load  = PROG_W'(PROG_CYC - 1);

  always_comb begin
    next_state = state;
    case (state)
      DPW_INIT: if (init_done) next_state = DPW_IDLE;
      DPW_IDLE: if (do_nv_wr || do_store) next_state = DPW_PROG;
      DPW_PROG: if (prog_done) next_state = DPW_IDLE;
      default:  next_state = DPW_INIT;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state    <= DPW_INIT;
      init_cnt <= INIT_W'(INIT_CYC - 1);
      prog_cnt <= '0;
    end else begin
      state    <= next_state;
      init_cnt <= (init_cnt == '0) ? init_cnt : init_cnt - 1'b1;
      prog_cnt <= (do_nv_wr || do_store) ? prog_load :
                  (prog_cnt == '0) ? prog_cnt : prog_cnt - 1'b1;
    end
  end

  // volatile wiper: cleared by reset (power loss), loaded at power-up
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) o_wiper <= WIPER_RESET;
    else if (init_done) o_wiper <= o_nv_value;
    else if (do_vol_wr) o_wiper <= data_pos;
    else if (do_recall) o_wiper <= o_nv_value;
  end

  // stored value: untouched by i_rst, committed when the timer runs out
  always_ff @(posedge i_clk or posedge i_nv_clear) begin
    if (i_nv_clear) begin
      o_nv_value <= NV_FACTORY;
      nv_pend    <= NV_FACTORY;
    end else begin
      if (do_nv_wr) nv_pend <= data_pos;
      else if (do_store) nv_pend <= o_wiper;
      if (prog_done) o_nv_value <= nv_pend;
    end
  end

  assign o_nv_busy = state == DPW_PROG;
  assign o_standby = state == DPW_IDLE && !bus_active_s;

  // helper for the load bound: cycles spent in power-up load
  logic [INIT_W-1:0]   init_age;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) init_age <= '0;
    else if (state == DPW_INIT && init_age != '1) init_age <= init_age + 1'b1;
  end

  // assertions and covers
  a_vol_write: assert property (@(posedge i_clk) disable iff (i_rst)
    do_vol_wr |=> o_wiper == $past(data_pos))
    else $error("wiper not loaded by volatile write");
  a_nv_keep_wiper: assert property (@(posedge i_clk) disable iff (i_rst)
    do_nv_wr |=> $stable(o_wiper) && o_nv_busy)
    else $error("stored write disturbed wiper");
  a_recall_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    do_recall |=> o_wiper == $past(o_nv_value))
    else $error("recall did not copy stored value");
  a_store_commit: assert property (@(posedge i_clk) disable iff (i_rst || i_nv_clear)
    do_store ##1 (o_nv_busy [*1]) ##0 (prog_cnt == prog_load) |-> nv_pend == $past(o_wiper))
    else $error("store captured wrong value");
  a_init_load: assert property (@(posedge i_clk) disable iff (i_rst)
    init_done |=> o_wiper == $past(o_nv_value) && state == DPW_IDLE)
    else $error("power-up load missing");
  a_init_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    state == DPW_INIT |-> init_age < INIT_W'(INIT_CYC))
    else $error("power-up load too slow");
  a_unknown_ignored: assert property (@(posedge i_clk) disable iff (i_rst)
    (cmd_evt && !(do_vol_wr || do_nv_wr || do_recall || do_store))
      |=> $stable(o_wiper) && $stable(nv_pend) && state == DPW_IDLE)
    else $error("unknown command changed state");
  a_standby_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    o_standby |-> !o_nv_busy && !bus_active_s)
    else $error("standby while busy");
  a_prog_commit: assert property (@(posedge i_clk) disable iff (i_rst || i_nv_clear)
    prog_done |=> o_nv_value == $past(nv_pend) && !o_nv_busy)
    else $error("stored value not committed");
  a_ack_drive: assert property (@(negedge i_scl) disable iff (i_rst)
    (bit_cnt == ACK_BIT && ack_pend) |=> o_sda_oe)
    else $error("acknowledge not driven");
  a_addr_miss: assert property (@(posedge i_scl) disable iff (i_rst)
    (!new_start && byte_end && at_addr && !addr_hit) |=> !ack_pend)
    else $error("foreign address acknowledged");

  c_vol_write: cover property (@(posedge i_clk) disable iff (i_rst) do_vol_wr);
  c_store: cover property (@(posedge i_clk) disable iff (i_rst) do_store ##1 o_nv_busy);
  c_recall: cover property (@(posedge i_clk) disable iff (i_rst) do_recall);
  c_prog_done: cover property (@(posedge i_clk) disable iff (i_rst) prog_done);
endmodule // dpw_wiper_cmd
`default_nettype wire
